// ---- design/sfr_xdata_register_map.sv ----
`timescale 1ns/10ps
module sfr_xdata_register_map #(
  parameter int CSFR_N = regmap_pkg::CSFR_NUM,
  parameter int DSFR_N = regmap_pkg::DSFR_NUM
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // CPU special function register bus
  input wire regmap_pkg::sfr_req_s sfr_req,
  output logic [7:0] sfr_rdata,
  // Distributed SFR modules
  input wire logic [DSFR_N-1:0][7:0] dist_rdata,
  output logic [DSFR_N-1:0] dist_wr,
  output logic [7:0] dist_wdata,
  // CPU external-data bus
  input wire regmap_pkg::xbus_req_s x_req,
  output logic [7:0] x_rdata,
  // Register contents towards the rest of the chip
  output logic [CSFR_N-1:0][7:0] csfr_value,
  output logic [regmap_pkg::NUM_XBYTES-1:0][7:0] trim_value
);

  localparam int NXB = regmap_pkg::NUM_XBYTES;

  // ******************************************************
  // SFR decode
  // ******************************************************
  logic sfr_space;
  logic [CSFR_N-1:0] csfr_hit;
  logic [DSFR_N-1:0] dsfr_hit;
  logic [7:0] next_sfr_rdata;
  logic [DSFR_N-1:0] next_dist_wr;

  // Addresses below the SFR space are internal RAM, never ours
  assign sfr_space = sfr_req.addr[regmap_pkg::SFR_SPACE_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < CSFR_N; gi++) begin : g_csfr
      assign csfr_hit[gi] = sfr_space &&
        (sfr_req.addr == (regmap_pkg::CSFR_BASE + 8'(gi)));
      byte_store #(.W(8)) u_csfr (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .reg_wr(sfr_req.wr && csfr_hit[gi]),
        .pack_wr(1'b0),
        .wdata(sfr_req.wdata),
        .value(csfr_value[gi])
      );
    end
    for (gi = 0; gi < DSFR_N; gi++) begin : g_dsfr
      assign dsfr_hit[gi] = sfr_space && (sfr_req.addr == regmap_pkg::DSFR_ADDR[gi]);
    end
  endgenerate

  assign next_dist_wr = sfr_req.wr ? dsfr_hit : '0;

  always_comb begin
    next_sfr_rdata = regmap_pkg::READ_ZERO;
    for (int i = 0; i < CSFR_N; i++) begin
      if (csfr_hit[i]) begin
        next_sfr_rdata = next_sfr_rdata | csfr_value[i];
      end
    end
    for (int j = 0; j < DSFR_N; j++) begin
      if (dsfr_hit[j]) begin
        next_sfr_rdata = next_sfr_rdata | dist_rdata[j];
      end
    end
  end

  // Write data is registered with the strobe so owners see it stable
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata <= regmap_pkg::READ_ZERO;
      dist_wr <= '0;
      dist_wdata <= regmap_pkg::BYTE_RST;
    end else begin
      if (sfr_req.rd) begin
        sfr_rdata <= next_sfr_rdata;
      end
      dist_wr <= next_dist_wr;
      dist_wdata <= sfr_req.wdata;
    end
  end

  // ******************************************************
  // External-data bank decode
  // ******************************************************
  logic [15:0] x_diff;
  logic x_in_win;
  logic [7:0] xofs;
  logic [NXB-1:0] reg_hit;
  logic [NXB-1:0] pack_hit;
  logic [7:0] next_x_rdata;

  // Only the external-data strobes reach this bank; the SFR bus cannot
  assign x_diff = x_req.addr - regmap_pkg::XREG_BASE;
  assign x_in_win = x_diff < regmap_pkg::XREG_SPAN;
  assign xofs = x_diff[7:0];

  generate
    for (gi = 0; gi < NXB; gi++) begin : g_xbyte
      assign reg_hit[gi] = x_in_win && (xofs == regmap_pkg::XBYTE_REG_OFS[gi]);
      assign pack_hit[gi] = x_in_win && regmap_pkg::XBYTE_HAS_PACK[gi] &&
        (xofs == regmap_pkg::XBYTE_PACK_OFS[gi]);
      byte_store #(.W(regmap_pkg::XBYTE_WIDTH[gi])) u_xbyte (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .reg_wr(x_req.wr && reg_hit[gi]),
        .pack_wr(x_req.wr && pack_hit[gi]),
        .wdata(x_req.wdata),
        .value(trim_value[gi])
      );
    end
  endgenerate

  // Unbacked bytes, such as the top byte of the 23-bit trim slot, match nothing
  always_comb begin
    next_x_rdata = regmap_pkg::READ_ZERO;
    for (int k = 0; k < NXB; k++) begin
      if (reg_hit[k] || pack_hit[k]) begin
        next_x_rdata = next_x_rdata | trim_value[k];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      x_rdata <= regmap_pkg::READ_ZERO;
    end else if (x_req.rd) begin
      x_rdata <= next_x_rdata;
    end
  end

  // ******************************************************
  // Checks
  // ******************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  central_write_a: assert property (
    sfr_req.wr && sfr_req.addr == regmap_pkg::CSFR_BASE |=> csfr_value[0] == $past(sfr_req.wdata)
  ) else $error("central SFR write lost");

  dist_strobe_a: assert property (
    sfr_req.wr && sfr_req.addr == regmap_pkg::DSFR_ADDR[0]
      |=> dist_wr[0] && dist_wdata == $past(sfr_req.wdata)
  ) else $error("distributed write strobe wrong");

  xbank_hold_a: assert property (
    !x_req.wr |=> $stable(trim_value)
  ) else $error("bank changed without a write");

  msb_first_a: assert property (
    x_req.wr && x_in_win && xofs == regmap_pkg::XOFS_TRIM1
      |=> trim_value[4] == $past(x_req.wdata)
  ) else $error("halfword MSB not at lowest address");

  lsb_plus3_a: assert property (
    x_req.wr && x_in_win && xofs == (regmap_pkg::XOFS_TRIM0 + 8'h03)
      |=> trim_value[0] == $past(x_req.wdata)
  ) else $error("word LSB not at base plus three");

  empty_byte_a: assert property (
    x_req.rd && x_in_win && xofs == regmap_pkg::XOFS_TRIM0 |=> x_rdata == regmap_pkg::READ_ZERO
  ) else $error("unbacked byte not zero");

  pack_write_a: assert property (
    x_req.wr && x_in_win && xofs == (regmap_pkg::XOFS_PACK + 8'h01)
      |=> trim_value[1] == $past(x_req.wdata)
  ) else $error("packed write missed storage");

  pack_order_a: assert property (
    x_req.rd && x_in_win && xofs == regmap_pkg::XOFS_PACK |=> x_rdata == $past(trim_value[0])
  ) else $error("packed byte 0 is not the LSB");

  shared_view_a: assert property (
    (x_req.wr && reg_hit[0]) ##1 (x_req.rd && pack_hit[0] && !x_req.wr)
      |=> x_rdata == $past(x_req.wdata, 2)
  ) else $error("views disagree after write");

endmodule

// ---- inc/regmap_pkg.sv ----
package regmap_pkg;

  // ******************************************************
  // Bus carriers
  // ******************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } sfr_req_s;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } xbus_req_s;

  // ******************************************************
  // Special function register space
  // ******************************************************
  localparam int SFR_SPACE_BIT = 7;
  localparam int CSFR_NUM = 4;
  localparam logic [7:0] CSFR_BASE = 8'hB0;
  localparam int DSFR_NUM = 4;
  localparam logic [7:0] DSFR_ADDR [DSFR_NUM] = '{8'hA8, 8'hA9, 8'hAA, 8'hAB};
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ******************************************************
  // External-data register space
  // ******************************************************
  localparam logic [15:0] XREG_BASE = 16'hF000;
  localparam logic [15:0] XREG_SPAN = 16'h0100;
  localparam logic [7:0] XOFS_TRIM0 = 8'h10;
  localparam logic [7:0] XOFS_TRIM1 = 8'h14;
  localparam logic [7:0] XOFS_TEST = 8'h18;
  localparam logic [7:0] XOFS_PACK = 8'h40;
  localparam int TRIM0_BITS = 23;
  localparam int NUM_XBYTES = 6;
  // Storage bytes, least significant first within each register
  localparam logic [7:0] XBYTE_REG_OFS [NUM_XBYTES] = '{
    XOFS_TRIM0 + 8'h03, XOFS_TRIM0 + 8'h02, XOFS_TRIM0 + 8'h01,
    XOFS_TRIM1 + 8'h01, XOFS_TRIM1, XOFS_TEST};
  localparam logic [7:0] XBYTE_PACK_OFS [NUM_XBYTES] = '{
    XOFS_PACK, XOFS_PACK + 8'h01, XOFS_PACK + 8'h02,
    XOFS_PACK + 8'h03, XOFS_PACK + 8'h04, XOFS_PACK};
  localparam logic XBYTE_HAS_PACK [NUM_XBYTES] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  localparam int XBYTE_WIDTH [NUM_XBYTES] = '{8, 8, TRIM0_BITS - 16, 8, 8, 8};

endpackage

// ---- design/byte_store.sv ----
`timescale 1ns/10ps
module byte_store #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Two write views onto one storage
  input wire logic reg_wr,
  input wire logic pack_wr,
  input wire logic [7:0] wdata,
  // Stored value, unimplemented bits zero
  output logic [7:0] value
);

  logic [W-1:0] store;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      store <= regmap_pkg::BYTE_RST[W-1:0];
    end else if (reg_wr || pack_wr) begin
      store <= wdata[W-1:0];
    end
  end

  generate
    if (W < 8) begin : g_pad
      assign value = {{(8 - W){1'b0}}, store};
    end else begin : g_full
      assign value = store;
    end
  endgenerate

endmodule

// ---- bench/dist_owner.sv ----
`timescale 1ns/10ps
module dist_owner (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Writes from the map, read data back
  input wire logic [3:0] dist_wr,
  input wire logic [7:0] dist_wdata,
  output logic [3:0][7:0] dist_rdata
);
  logic [3:0][7:0] store;
  // Combinational so the byte is there in the read cycle
  assign dist_rdata = store;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      store <= '0;
    end else begin
      for (int j = 0; j < 4; j++) begin
        if (dist_wr[j]) begin
          store[j] <= dist_wdata;
        end
      end
    end
  end
endmodule

// ---- bench/sfr_xdata_register_map_test.sv ----
`timescale 1ns/10ps
module sfr_xdata_register_map_test;
  logic ref_clk;
  logic resetn;
  regmap_pkg::sfr_req_s sfr_req;
  regmap_pkg::xbus_req_s x_req;
  logic [7:0] sfr_rdata;
  logic [7:0] x_rdata;
  logic [3:0][7:0] dr;
  logic [3:0] dw;
  logic [7:0] dd;
  logic [3:0][7:0] cv;
  logic [5:0][7:0] tv;
  logic [7:0] sq[$];
  logic [7:0] xq[$];
  logic [7:0] v [8];
  logic ps;
  logic px;
  logic [7:0] c3;
  logic [31:0] seed = 32'h5B1D;
  int err_total = 0;
  int check_count = 0;

  sfr_xdata_register_map u_dut (.ref_clk(ref_clk), .resetn(resetn),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .dist_rdata(dr),
    .dist_wr(dw), .dist_wdata(dd), .x_req(x_req), .x_rdata(x_rdata),
    .csfr_value(cv), .trim_value(tv));
  dist_owner u_owner (.ref_clk(ref_clk), .resetn(resetn),
    .dist_wr(dw), .dist_wdata(dd), .dist_rdata(dr));

  always #2.5 ref_clk = ~ref_clk;

  // ******************************************************
  // Stimulus helpers
  // ******************************************************
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus cycle; reads note their expected byte in the queue
  task automatic op(input logic x, input logic [15:0] a, input logic w,
                    input logic [7:0] d, input logic [7:0] e);
    @(negedge ref_clk);
    sfr_req <= x ? '0 : {a[7:0], !w, w, d};
    x_req <= x ? {a, !w, w, d} : '0;
    if (!w && x) xq.push_back(e);
    if (!w && !x) sq.push_back(e);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ******************************************************
  // Read data monitor
  // ******************************************************
  always @(posedge ref_clk) begin
    ps <= sfr_req.rd;
    px <= x_req.rd;
  end
  always @(negedge ref_clk) begin
    if (ps) chk(sfr_rdata, sq.pop_front());
    if (px) chk(x_rdata, xq.pop_front());
  end

  initial begin
    repeat (3000) @(posedge ref_clk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    sfr_req = '0;
    x_req = '0;
    repeat (5) @(negedge ref_clk);
    resetn = 1'b1;
    for (int i = 0; i < 8; i++) begin
      v[i] = rnd();
      op(0, (i < 4 ? 16'hB0 : 16'hA4) + 16'(i), 1, v[i], 0);
    end
    for (int i = 0; i < 8; i++) begin
      op(0, (i < 4 ? 16'hB0 : 16'hA4) + 16'(i), 0, 0, v[i]);
    end
    op(0, 16'h00A0, 0, 0, 8'h00);
    // Keep the central byte written above; the data array is reused below
    c3 = v[3];
    for (int i = 0; i < 6; i++) v[i] = rnd();
    op(1, 16'hF013, 1, v[0], 0);
    op(1, 16'hF012, 1, v[1], 0);
    op(1, 16'hF011, 1, 8'hFF, 0);
    op(1, 16'hF040, 0, 0, v[0]);
    op(1, 16'hF041, 0, 0, v[1]);
    op(1, 16'hF042, 0, 0, 8'h7F);
    op(1, 16'hF010, 0, 0, 8'h00);
    op(1, 16'hF043, 1, v[2], 0);
    op(1, 16'hF044, 1, v[3], 0);
    op(1, 16'hF015, 0, 0, v[2]);
    op(1, 16'hF014, 0, 0, v[3]);
    op(1, 16'hF011, 0, 0, 8'h7F);
    op(1, 16'hF018, 1, v[4], 0);
    op(1, 16'hE018, 1, ~v[4], 0);
    op(1, 16'hF018, 0, 0, v[4]);
    op(1, 16'hE018, 0, 0, 8'h00);
    op(1, 16'hF0FF, 0, 0, 8'h00);
    op(1, 16'hF0FF, 0, 0, 8'h00);
    // Packed write seen through the regular view, then the reverse back to back
    op(1, 16'hF041, 1, v[5], 0);
    op(1, 16'hF012, 0, 0, v[5]);
    op(1, 16'hF013, 1, ~v[0], 0);
    op(1, 16'hF040, 0, 0, ~v[0]);
    @(negedge ref_clk);
    sfr_req <= '0;
    x_req <= '0;
    repeat (3) @(negedge ref_clk);
    chk(tv[0], ~v[0]);
    chk(tv[2], 8'h7F);
    chk(cv[3], c3);
    if (sq.size() + xq.size() != 0) err_total++;
    tally_and_finish();
  end
endmodule
